/* src/dc_brake_pkg.sv */
// Purpose: shared constants and types for the dc injection brake sequencer
// Assumes: 10 MHz system clock, register port with one-cycle read latency
// Notes:   frequencies in 0.01 Hz, times in 0.1 s, forces in percent, carrier in 0.1 kHz
package dc_brake_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] OFS_INTERNAL_ENABLE = 4'h0;
   localparam logic [3:0] OFS_ONSET_FREQ      = 4'h1;
   localparam logic [3:0] OFS_WAIT_INTERVAL   = 4'h2;
   localparam logic [3:0] OFS_STOP_FORCE      = 4'h3;
   localparam logic [3:0] OFS_STOP_DURATION   = 4'h4;
   localparam logic [3:0] OFS_TRIGGER_DETECT  = 4'h5;
   localparam logic [3:0] OFS_START_FORCE     = 4'h6;
   localparam logic [3:0] OFS_START_DURATION  = 4'h7;
   localparam logic [3:0] OFS_CARRIER_FREQ    = 4'h8;
   localparam logic [3:0] OFS_PAUSE_FREQ      = 4'h9;
   localparam logic [3:0] OFS_PAUSE_TIME      = 4'ha;
   localparam logic [3:0] OFS_EXT_ASSIGN      = 4'hb;
   localparam logic [3:0] OFS_STATUS          = 4'hc;
   localparam logic [3:0] OFS_OUTPUT_FREQ     = 4'hd;

   // ---------------------------------------------------------------
   // reset values and codes
   // ---------------------------------------------------------------
   localparam logic [7:0]  RST_INTERNAL_ENABLE = 8'h00;
   localparam logic [15:0] RST_ONSET_FREQ      = 16'h0032;  // 0.50 Hz
   localparam logic [15:0] RST_ZERO16          = 16'h0000;
   localparam logic [7:0]  RST_TRIGGER_DETECT  = 8'h01;
   localparam logic [15:0] RST_CARRIER_FREQ    = 16'h001e;  // 3.0 kHz
   localparam logic [7:0]  RST_EXT_ASSIGN      = 8'h00;
   localparam logic [7:0]  CODE_ENABLE         = 8'h01;
   localparam logic [7:0]  CODE_EDGE           = 8'h00;
   localparam logic [7:0]  CODE_EXT_BRAKE_FUNC = 8'h07;

   // ---------------------------------------------------------------
   // limits and timing
   // ---------------------------------------------------------------
   localparam logic [15:0] MAX_ONSET_FREQ  = 16'h1770;  // 60.00 Hz
   localparam logic [15:0] MAX_WAIT        = 16'h0032;  // 5.0 s
   localparam logic [15:0] MAX_DURATION    = 16'h0258;  // 60.0 s
   localparam logic [15:0] MAX_FORCE       = 16'h0046;  // 70 %
   localparam logic [15:0] MIN_CARRIER     = 16'h0005;  // 0.5 kHz
   localparam logic [15:0] MAX_CARRIER     = 16'h0078;  // 12 kHz
   localparam logic [15:0] PCT_FULL        = 16'h0064;  // 100 %
   localparam int          CLK_HZ          = 10_000_000;
   localparam int          TENTH_SEC_NS    = 100_000_000;
   localparam int          CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
   localparam int          TENTH_CYCLES    = TENTH_SEC_NS / CLK_PERIOD_NS;
   localparam int          CARRIER_UNIT_HZ = 100;  // carrier setting step

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT, ST_STOP_BRAKE, ST_START_BRAKE, ST_EXT_BRAKE, ST_PAUSE
   } brake_state_e;

   // drive status word seen by software through the status register
   typedef struct packed {
      logic       run_cmd;
      logic       motor_stopped;
      logic       switching_on;
      logic       inject;
      logic       accel_allow;
      logic [2:0] state;
   } brake_status_s;

endpackage

/* src/param_store.sv */
// Purpose: register file of braking parameters with registered read data
// Assumes: one write or read strobe per cycle
// Notes:   unmapped offsets read zero; writes to read-only words are dropped
`timescale 1ns/1ns
module param_store (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_b_in,
   input  wire logic [3:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   input  wire logic [7:0]  status_in,
   input  wire logic [15:0] out_freq_in,
   output logic [15:0]      rdata_out,
   output logic [15:0]      words_out [0:11]
);

   logic [15:0] word_reg [0:11];

   // ---------------------------------------------------------------
   // parameter words
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int i = 0; i < 12; i++) begin
            word_reg[i] <= dc_brake_pkg::RST_ZERO16;
         end
         word_reg[dc_brake_pkg::OFS_INTERNAL_ENABLE] <= {8'h00, dc_brake_pkg::RST_INTERNAL_ENABLE};
         word_reg[dc_brake_pkg::OFS_ONSET_FREQ]      <= dc_brake_pkg::RST_ONSET_FREQ;
         word_reg[dc_brake_pkg::OFS_TRIGGER_DETECT]  <= {8'h00, dc_brake_pkg::RST_TRIGGER_DETECT};
         word_reg[dc_brake_pkg::OFS_CARRIER_FREQ]    <= dc_brake_pkg::RST_CARRIER_FREQ;
         word_reg[dc_brake_pkg::OFS_EXT_ASSIGN]      <= {8'h00, dc_brake_pkg::RST_EXT_ASSIGN};
      end else if (wr_in && addr_in < 4'hc) begin
         word_reg[addr_in] <= wdata_in;
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_out <= 16'h0000;
      end else if (rd_in) begin
         if (addr_in < 4'hc) begin
            rdata_out <= word_reg[addr_in];
         end else if (addr_in == dc_brake_pkg::OFS_STATUS) begin
            rdata_out <= {8'h00, status_in};
         end else if (addr_in == dc_brake_pkg::OFS_OUTPUT_FREQ) begin
            rdata_out <= out_freq_in;
         end else begin
            rdata_out <= 16'h0000;
         end
      end else begin
         rdata_out <= 16'h0000;
      end
   end

   assign words_out = word_reg;

endmodule // param_store

/* src/dc_brake_sequencer.sv */
// Purpose: dc injection brake sequencer with pulse generator and accel pause
// Assumes: 10 MHz clock; ext brake, run and stopped inputs are asynchronous pins
// Notes:   frequencies 0.01 Hz, times 0.1 s, forces percent, carrier 0.1 kHz
//
// Operation
// - enable code 01 brakes automatically at stop and start; 00 disables internal braking
// - decel braking begins when output frequency falls to the onset frequency
// - after onset or external edge request, wait programmed interval coasting
// - stop force percentage, up to 70, scales decel braking
// - internal decel braking lasts the stop duration, then ends
// - start braking on run command injects at start force before acceleration
// - start braking lasts start duration, then acceleration is allowed
// - terminal function 7 makes the external input the source; enable ignored
// - external mode uses force levels but not durations
// - trigger detect 00 selects edge, 01 level, default 01
// - level mode brakes while input asserted in run and stop
// - edge in run starts braking, held until motor stops
// - edge mode ignores rising edges in stop state
// - injection pulses run at a dedicated carrier, 0.5 to 12 kHz, default 3.0
// - maximum force falls as carrier setting rises
// - accel pause holds frequency at pause point for pause time
`timescale 1ns/1ns
module dc_brake_sequencer (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_b_in,
   input  wire logic [3:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [15:0]      rdata_out,
   input  wire logic        external_brake_input_in,
   input  wire logic        run_cmd_in,
   input  wire logic        motor_stopped_in,
   input  wire logic [15:0] output_freq_in,
   output logic             inject_out,
   output logic             switching_on_out,
   output logic             accel_allow_out,
   output logic             freq_hold_out,
   output logic [7:0]       brake_duty_out
);

   logic [15:0]  words [0:11];
   logic [7:0]   status_word;
   dc_brake_pkg::brake_status_s status_fields;
   // pin synchronisers and their filtered copies
   logic [2:0]   ext_sync_reg;
   logic [2:0]   run_sync_reg;
   logic [2:0]   stop_sync_reg;
   logic         ext_reg;
   logic         run_reg;
   logic         stopped_reg;
   logic         ext_prev_reg;
   logic         run_prev_reg;
   logic [15:0]  freq_prev_reg;

   // sequence state and timers
   dc_brake_pkg::brake_state_e state_reg;
   dc_brake_pkg::brake_state_e wait_target_reg;
   logic [19:0]  tenth_count_reg;
   logic         tenth_reg;
   logic [15:0]  elapsed_reg;

   // carrier timing and force
   logic [15:0]  carrier_count_reg;
   logic [15:0]  carrier_period;
   logic [15:0]  on_cycles;
   logic [7:0]   force_pct;
   logic [7:0]   force_cap;

   // decoded modes and events
   logic         ext_mode;
   logic         edge_mode;
   logic         int_enable;
   logic         ext_rise;
   logic         run_rise;
   logic         decel_onset;
   logic         pause_point;
   logic         want_inject;

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   param_store u_store (
      .clk_sys_in  (clk_sys_in),
      .rst_b_in    (rst_b_in),
      .addr_in     (addr_in),
      .wdata_in    (wdata_in),
      .wr_in       (wr_in),
      .rd_in       (rd_in),
      .status_in   (status_word),
      .out_freq_in (output_freq_in),
      .rdata_out   (rdata_out),
      .words_out   (words)
   );

   // clamp a setting to its documented upper bound
   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] hi);
      clamp16 = (v > hi) ? hi : v;
   endfunction

   // tenths of a second to compare against elapsed counter
   function automatic logic done_time(input logic [15:0] elapsed, input logic [15:0] setting,
                                      input logic [15:0] hi);
      done_time = (elapsed >= clamp16(setting, hi));
   endfunction

   // ---------------------------------------------------------------
   // configuration decode
   // ---------------------------------------------------------------
   assign ext_mode   = (words[dc_brake_pkg::OFS_EXT_ASSIGN][7:0] == dc_brake_pkg::CODE_EXT_BRAKE_FUNC);
   assign edge_mode  = (words[dc_brake_pkg::OFS_TRIGGER_DETECT][7:0] == dc_brake_pkg::CODE_EDGE);
   assign int_enable = !ext_mode &&
                       (words[dc_brake_pkg::OFS_INTERNAL_ENABLE][7:0] == dc_brake_pkg::CODE_ENABLE);

   // ---------------------------------------------------------------
   // input synchronisers, second and third stage must agree
   // a level is taken only when two stages agree, so one metastable
   // sample can never start or end a braking phase
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ext_sync_reg  <= 3'h0;
         run_sync_reg  <= 3'h0;
         stop_sync_reg <= 3'h7;
      end else begin
         ext_sync_reg  <= {ext_sync_reg[1:0], external_brake_input_in};
         run_sync_reg  <= {run_sync_reg[1:0], run_cmd_in};
         stop_sync_reg <= {stop_sync_reg[1:0], motor_stopped_in};
      end
   end

   // filtered levels and previous values for edges
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ext_reg       <= 1'b0;
         run_reg       <= 1'b0;
         stopped_reg   <= 1'b1;
         ext_prev_reg  <= 1'b0;
         run_prev_reg  <= 1'b0;
         freq_prev_reg <= 16'h0000;
      end else begin
         if (ext_sync_reg[1] == ext_sync_reg[2]) begin
            ext_reg <= ext_sync_reg[2];
         end
         if (run_sync_reg[1] == run_sync_reg[2]) begin
            run_reg <= run_sync_reg[2];
         end
         if (stop_sync_reg[1] == stop_sync_reg[2]) begin
            stopped_reg <= stop_sync_reg[2];
         end
         ext_prev_reg  <= ext_reg;
         run_prev_reg  <= run_reg;
         freq_prev_reg <= output_freq_in;
      end
   end

   assign ext_rise    = ext_reg && !ext_prev_reg;
   assign run_rise    = run_reg && !run_prev_reg;
   // decel onset: frequency falling and crossing the onset threshold
   assign decel_onset = !run_reg && (output_freq_in < freq_prev_reg) &&
                        (output_freq_in <= clamp16(words[dc_brake_pkg::OFS_ONSET_FREQ],
                                                   dc_brake_pkg::MAX_ONSET_FREQ)) &&
                        (freq_prev_reg > clamp16(words[dc_brake_pkg::OFS_ONSET_FREQ],
                                                 dc_brake_pkg::MAX_ONSET_FREQ));
   assign pause_point = run_reg && (words[dc_brake_pkg::OFS_PAUSE_FREQ] != 16'h0000) &&
                        (freq_prev_reg < words[dc_brake_pkg::OFS_PAUSE_FREQ]) &&
                        (output_freq_in >= words[dc_brake_pkg::OFS_PAUSE_FREQ]);

   // ---------------------------------------------------------------
   // tenth-second tick and elapsed counter
   // ---------------------------------------------------------------
   // a tenth of a second is a million cycles: the divider needs 20 bits,
   // a narrower one would wrap early and shorten every programmed time
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tenth_count_reg <= 20'h00000;
         tenth_reg       <= 1'b0;
      end else if (tenth_count_reg == 20'(dc_brake_pkg::TENTH_CYCLES - 1)) begin
         tenth_count_reg <= 20'h00000;
         tenth_reg       <= 1'b1;
      end else begin
         tenth_count_reg <= tenth_count_reg + 20'h00001;
         tenth_reg       <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // braking sequence
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg       <= dc_brake_pkg::ST_IDLE;
         wait_target_reg <= dc_brake_pkg::ST_IDLE;
         elapsed_reg     <= 16'h0000;
      end else begin
         unique case (state_reg)
            dc_brake_pkg::ST_IDLE: begin
               elapsed_reg <= 16'h0000;
               // external control outranks the internal enable
               if (ext_mode && !edge_mode && ext_reg) begin
                  state_reg <= dc_brake_pkg::ST_EXT_BRAKE;
               end else if (ext_mode && edge_mode && ext_rise && run_reg) begin
                  state_reg <= dc_brake_pkg::ST_WAIT;
                  wait_target_reg <= dc_brake_pkg::ST_EXT_BRAKE;
               end else if (int_enable && run_rise) begin
                  state_reg <= dc_brake_pkg::ST_START_BRAKE;
               end else if (int_enable && decel_onset) begin
                  state_reg <= dc_brake_pkg::ST_WAIT;
                  wait_target_reg <= dc_brake_pkg::ST_STOP_BRAKE;
               end else if (pause_point) begin
                  state_reg <= dc_brake_pkg::ST_PAUSE;
               end
            end

            dc_brake_pkg::ST_WAIT: begin
               elapsed_reg <= elapsed_reg + {15'h0000, tenth_reg};
               if (ext_mode && !edge_mode) begin
                  state_reg <= dc_brake_pkg::ST_IDLE;
               end else if (done_time(elapsed_reg, words[dc_brake_pkg::OFS_WAIT_INTERVAL],
                                      dc_brake_pkg::MAX_WAIT)) begin
                  state_reg   <= wait_target_reg;
                  elapsed_reg <= 16'h0000;
               end
            end

            dc_brake_pkg::ST_STOP_BRAKE: begin
               elapsed_reg <= elapsed_reg + {15'h0000, tenth_reg};
               if (done_time(elapsed_reg, words[dc_brake_pkg::OFS_STOP_DURATION],
                             dc_brake_pkg::MAX_DURATION) || run_rise) begin
                  state_reg <= dc_brake_pkg::ST_IDLE;
               end
            end

            dc_brake_pkg::ST_START_BRAKE: begin
               elapsed_reg <= elapsed_reg + {15'h0000, tenth_reg};
               if (done_time(elapsed_reg, words[dc_brake_pkg::OFS_START_DURATION],
                             dc_brake_pkg::MAX_DURATION) || !run_reg) begin
                  state_reg <= dc_brake_pkg::ST_IDLE;
               end
            end

            dc_brake_pkg::ST_EXT_BRAKE: begin
               if (!ext_mode) begin
                  state_reg <= dc_brake_pkg::ST_IDLE;
               end else if (!edge_mode && !ext_reg) begin
                  state_reg <= dc_brake_pkg::ST_IDLE;
               end else if (edge_mode && stopped_reg) begin
                  state_reg <= dc_brake_pkg::ST_IDLE;
               end
            end

            dc_brake_pkg::ST_PAUSE: begin
               elapsed_reg <= elapsed_reg + {15'h0000, tenth_reg};
               if (done_time(elapsed_reg, words[dc_brake_pkg::OFS_PAUSE_TIME],
                             dc_brake_pkg::MAX_DURATION) || !run_reg) begin
                  state_reg <= dc_brake_pkg::ST_IDLE;
               end
            end

            default: begin
               state_reg <= dc_brake_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // force selection, derating and carrier timing
   // ---------------------------------------------------------------
   // derating: cap falls linearly from 70 at 0.5 kHz toward 32 at 12 kHz
   always_comb begin
      logic [15:0] car;
      car       = words[dc_brake_pkg::OFS_CARRIER_FREQ];
      if (car < dc_brake_pkg::MIN_CARRIER) begin
         car = dc_brake_pkg::MIN_CARRIER;
      end
      car       = clamp16(car, dc_brake_pkg::MAX_CARRIER);
      force_cap = 8'(dc_brake_pkg::MAX_FORCE - ((car - dc_brake_pkg::MIN_CARRIER) / 16'h0003));
      carrier_period = 16'((dc_brake_pkg::CLK_HZ / dc_brake_pkg::CARRIER_UNIT_HZ) / int'(car));
   end

   // pick stop or start force by the phase being injected
   always_comb begin
      logic [15:0] f;
      f = (state_reg == dc_brake_pkg::ST_START_BRAKE ||
           (state_reg == dc_brake_pkg::ST_EXT_BRAKE && !edge_mode && !run_reg))
          ? words[dc_brake_pkg::OFS_START_FORCE] : words[dc_brake_pkg::OFS_STOP_FORCE];
      f = clamp16(f, dc_brake_pkg::MAX_FORCE);
      force_pct = (f[7:0] > force_cap) ? force_cap : f[7:0];
   end

   // on-time is the force share of one carrier period
   assign on_cycles   = 16'((32'(carrier_period) * 32'(force_pct)) / 32'(dc_brake_pkg::PCT_FULL));
   assign want_inject = (state_reg == dc_brake_pkg::ST_STOP_BRAKE) ||
                        (state_reg == dc_brake_pkg::ST_START_BRAKE) ||
                        (state_reg == dc_brake_pkg::ST_EXT_BRAKE) ||
                        (state_reg == dc_brake_pkg::ST_WAIT &&
                         words[dc_brake_pkg::OFS_WAIT_INTERVAL] == 16'h0000);

   // carrier period counter, restarted while idle
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         carrier_count_reg <= 16'h0000;
      end else if (!want_inject || carrier_count_reg >= carrier_period - 16'h0001) begin
         carrier_count_reg <= 16'h0000;
      end else begin
         carrier_count_reg <= carrier_count_reg + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         inject_out       <= 1'b0;
         switching_on_out <= 1'b0;
         accel_allow_out  <= 1'b0;
         freq_hold_out    <= 1'b0;
         brake_duty_out   <= 8'h00;
      end else begin
         // switching stays on except while coasting out a non-zero wait
         inject_out       <= want_inject && (carrier_count_reg < on_cycles);
         switching_on_out <= (state_reg != dc_brake_pkg::ST_WAIT) || want_inject;
         accel_allow_out  <= run_reg && (state_reg == dc_brake_pkg::ST_IDLE) && !run_rise;
         freq_hold_out    <= (state_reg == dc_brake_pkg::ST_PAUSE);
         brake_duty_out   <= want_inject ? force_pct : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // status word for software
   // ---------------------------------------------------------------
   // fields taken from registered copies so reads see settled values
   always_comb begin
      status_fields.run_cmd       = run_reg;
      status_fields.motor_stopped = stopped_reg;
      status_fields.switching_on  = switching_on_out;
      status_fields.inject        = inject_out;
      status_fields.accel_allow   = accel_allow_out;
      status_fields.state         = 3'(state_reg);
   end

   assign status_word = status_fields;

endmodule // dc_brake_sequencer

/* testbench/dc_brake_sequencer_sva.sv */
// Purpose: port assertions for the brake sequencer
// Assumes: mode words are learned from port writes
// Notes:   bound into every sequencer
`timescale 1ns/1ns
module dc_brake_sequencer_sva (
   input wire logic        clk_sys_in,
   input wire logic        rst_b_in,
   input wire logic [3:0]  addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic        external_brake_input_in,
   input wire logic        run_cmd_in,
   input wire logic        inject_out,
   input wire logic        switching_on_out,
   input wire logic        accel_allow_out,
   input wire logic        freq_hold_out,
   input wire logic [7:0]  brake_duty_out
);
   logic trig_reg, ext_reg;
   // shadow of trigger detect and terminal function
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) {trig_reg, ext_reg} <= 2'b10;
      else if (wr_in && addr_in == 4'h5) trig_reg <= (wdata_in[7:0] == 8'h01);
      else if (wr_in && addr_in == 4'hb) ext_reg <= (wdata_in[7:0] == 8'h07);
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   property p_wait_quiet; !switching_on_out |-> !inject_out; endproperty
   a_wait_quiet: assert property (p_wait_quiet) else $error("inject while coasting");
   property p_duty_cap; brake_duty_out <= 8'h46; endproperty
   a_duty_cap: assert property (p_duty_cap) else $error("duty above limit");
   property p_read_idle; !rd_in |=> rdata_out == 16'h0000; endproperty
   a_read_idle: assert property (p_read_idle) else $error("read data without read");
   property p_accel_clear; accel_allow_out |-> !inject_out && brake_duty_out == 8'h00; endproperty
   a_accel_clear: assert property (p_accel_clear) else $error("accel during braking");
   property p_run_low; (!run_cmd_in)[*8] |-> !accel_allow_out; endproperty
   a_run_low: assert property (p_run_low) else $error("accel without run");
   property p_level_off; (trig_reg && ext_reg && !external_brake_input_in)[*8] |-> !inject_out; endproperty
   a_level_off: assert property (p_level_off) else $error("inject after release");
   property p_hold_quiet; freq_hold_out |-> !inject_out; endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("inject during pause");
   property p_inject_duty; inject_out |-> brake_duty_out != 8'h00; endproperty
   a_inject_duty: assert property (p_inject_duty) else $error("inject at zero duty");
   property p_reset_quiet; $rose(rst_b_in) |-> !inject_out && brake_duty_out == 8'h00; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("output after reset");
   c_inject: cover property (inject_out);
   c_accel: cover property (accel_allow_out);
   c_level: cover property (trig_reg && ext_reg && external_brake_input_in);
endmodule // dc_brake_sequencer_sva
bind dc_brake_sequencer dc_brake_sequencer_sva u_sva (.clk_sys_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in,
   .rdata_out, .external_brake_input_in, .run_cmd_in, .inject_out, .switching_on_out, .accel_allow_out,
   .freq_hold_out, .brake_duty_out);

/* testbench/motor_load_model.sv */
// Purpose: behavioural induction motor and load
// Assumes: speed moves 0.01 Hz per cycle
// Notes:   stopped at zero speed
`timescale 1ns/1ns
module motor_load_model (
   input  wire logic       clk_sys_in,
   input  wire logic       rst_b_in,
   input  wire logic       run_in,
   input  wire logic [7:0] duty_in,
   output logic [15:0]     freq_out,
   output logic            stopped_out
);
   // ramps up on run, brakes or coasts down otherwise
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) freq_out <= 16'h0000;
      else if (duty_in != 8'h00 || !run_in) freq_out <= (freq_out == 16'h0000) ? 16'h0000 : freq_out - 16'h0001;
      else if (freq_out < 16'h03e8) freq_out <= freq_out + 16'h0001;
   end
   assign stopped_out = (freq_out == 16'h0000);
endmodule // motor_load_model

/* testbench/dc_brake_sequencer_test.sv */
// Purpose: self-checking bench for the brake sequencer
// Assumes: zero wait and external brake control
// Notes:   register shadow model in sh
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module dc_brake_sequencer_test;
   logic        clk_sys_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, ext_in = 1'b0, run_in = 1'b0;
   logic [3:0]  addr_in = 4'h0;
   logic [15:0] wdata_in = 16'h0000, rdata_out, freq;
   logic        inject_out, stopped, sw, accel;
   logic [7:0]  duty;
   int          err_total = 0, checked = 0, seed = 32'h0d5f, sh [16], f, exp, i;
   always #50 clk_sys_in = ~clk_sys_in;
   dc_brake_sequencer u_dc_brake_sequencer (.clk_sys_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .external_brake_input_in(ext_in), .run_cmd_in(run_in), .motor_stopped_in(stopped), .output_freq_in(freq),
      .inject_out, .switching_on_out(sw), .accel_allow_out(accel), .freq_hold_out(), .brake_duty_out(duty));
   motor_load_model u_motor_load_model (.clk_sys_in, .rst_b_in, .run_in, .duty_in(duty), .freq_out(freq),
      .stopped_out(stopped));
   // one-cycle register write, shadow follows
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
      sh[a] = d;
   endtask
   // read, then compare with shadow in the answer cycle
   task automatic rd_chk(input logic [3:0] a);
      @(posedge clk_sys_in);
      {addr_in, rd_in} <= {a, 1'b1};
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 `CHK(rdata_out, 16'(sh[a]))
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // main sequence
   initial begin
      foreach (sh[k]) sh[k] = 0;
      {sh[1], sh[5], sh[8], sh[12]} = {32'h32, 32'h1, 32'h1e, 32'h60};
      repeat (16) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      for (i = 0; i < 16; i++) rd_chk(i[3:0]);
      f = 1 + ($unsigned($random(seed)) % 70);
      exp = f < 70 - (120 - 5) / 3 ? f : 70 - (120 - 5) / 3;
      wr(4'h3, f[15:0]);
      wr(4'h6, f[15:0]);
      wr(4'h8, 16'h0078);
      wr(4'h0, 16'h0001);
      wr(4'h7, 16'h0001);
      wr(4'hb, 16'h0007);
      for (i = 0; i < 12; i++) rd_chk(i[3:0]);
      // level brake in stop state, checked again 1500 cycles later
      @(posedge clk_sys_in);
      ext_in <= 1'b1;
      for (i = 0; i < 2000 && inject_out !== 1'b1; i++) @(negedge clk_sys_in);
      `CHK(duty, 8'(exp))
      `CHK(sw, 1'b1)
      repeat (1500) @(negedge clk_sys_in);
      `CHK(duty, 8'(exp))
      @(posedge clk_sys_in);
      ext_in <= 1'b0;
      run_in <= 1'b1;
      repeat (20) @(negedge clk_sys_in);
      `CHK(duty, 8'h00)
      `CHK(accel, 1'b1)
      wr(4'h5, 16'h0000);
      repeat (1200) @(posedge clk_sys_in);
      ext_in <= 1'b1;
      for (i = 0; i < 1000 && duty === 8'h00; i++) @(negedge clk_sys_in);
      `CHK(duty, 8'(exp))
      for (i = 0; i < 3000 && !stopped; i++) @(negedge clk_sys_in);
      repeat (10) @(negedge clk_sys_in);
      `CHK(duty, 8'h00)
      @(posedge clk_sys_in);
      {ext_in, run_in} <= 2'b00;
      repeat (1500) @(posedge clk_sys_in);
      ext_in <= 1'b1;
      for (i = 0; i < 2000 && duty === 8'h00; i++) @(negedge clk_sys_in);
      `CHK(duty, 8'h00)
      wrap_up;
   end
   // cut a hang short
   initial begin
      #(40_000 * 100);
      err_total++;
      wrap_up;
   end
endmodule // dc_brake_sequencer_test
